// ==== tcr_pkg.sv ====
package tcr_pkg;
    // clock rate and timing figures
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned TCONV_US = 750000;
    localparam int unsigned TCONV_CYC = TCONV_US * CLK_MHZ;
    localparam int unsigned TWR_US = 10000;
    localparam int unsigned TWR_CYC = TWR_US * CLK_MHZ;
    localparam int unsigned SPU_MAX_US = 10;
    localparam int unsigned SPU_MAX_CYC = SPU_MAX_US * CLK_MHZ;
    localparam int unsigned CNT_W = 32;

    // link command codes
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_COPY = 8'h48;

    // resolution field codes and reset values
    localparam logic [1:0] RES_9 = 2'h0;
    localparam logic [1:0] RES_12 = 2'h3;
    localparam logic [1:0] RES_RST = RES_12;
    localparam logic [7:0] TH_RST = 8'h7f;
    localparam logic [7:0] TL_RST = 8'h80;
    localparam logic [15:0] TEMP_RST = 16'h0550;
    localparam int unsigned SIGN_BIT = 11;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CFG = 5'h04;
    localparam logic [4:0] OFS_STAT = 5'h08;
    localparam logic [4:0] OFS_TEMP = 5'h0c;
    localparam logic [4:0] OFS_IRQ_STS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MSK = 5'h14;
    localparam logic [4:0] OFS_NVCFG = 5'h18;

    // control bits
    localparam int unsigned CTRL_CONVERT = 0;
    localparam int unsigned CTRL_COPY = 1;
    localparam int unsigned CTRL_CFG_PUSH = 2;

    // config and nv-config fields
    localparam int unsigned CFG_RES_LSB = 0;
    localparam int unsigned CFG_TH_LSB = 8;
    localparam int unsigned CFG_TL_LSB = 16;

    // status bits
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_SPU = 1;
    localparam int unsigned STAT_ALARM = 2;
    localparam int unsigned STAT_DEV_BUSY = 3;
    localparam int unsigned STAT_PWR_FAULT = 4;

    // interrupt bits
    localparam int unsigned IRQ_CONV_DONE = 0;
    localparam int unsigned IRQ_COPY_DONE = 1;
    localparam int unsigned IRQ_REFUSED = 2;
    localparam int unsigned IRQ_W = 3;

    typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_COPY} tcr_dev_state_t;
    typedef enum logic [1:0] {MST_IDLE, MST_ARM, MST_HOLD} tcr_mst_state_t;
endpackage

// ==== tcr_link_if.sv ====
`timescale 1ns/10ps
interface tcr_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic cfg_wr;
    logic [1:0] cfg_res;
    logic [7:0] cfg_th;
    logic [7:0] cfg_tl;
    logic spu;
    logic busy;
    logic alarm;
    logic pwr_fault;
    logic [15:0] temp;
    logic [17:0] nv_cfg;

    modport dev (
        input cmd_valid, cmd_code, cfg_wr, cfg_res, cfg_th, cfg_tl, spu,
        output busy, alarm, pwr_fault, temp, nv_cfg
    );
    modport mst (
        output cmd_valid, cmd_code, cfg_wr, cfg_res, cfg_th, cfg_tl, spu,
        input busy, alarm, pwr_fault, temp, nv_cfg
    );
endinterface

// ==== tcr_sensor_dev.sv ====
`timescale 1ns/10ps
module tcr_sensor_dev
#(
    parameter int unsigned CONV_CYCLES = tcr_pkg::TCONV_CYC,
    parameter int unsigned WR_CYCLES = tcr_pkg::TWR_CYC,
    parameter int unsigned SPU_GRACE = tcr_pkg::SPU_MAX_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [11:0] i_sense_temp,
    output logic o_alarm,
    output logic o_busy,
    tcr_link_if.dev link
);
    import tcr_pkg::*;

    tcr_dev_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] grace_r, grace_nxt;
    logic [1:0] res_r, res_nxt;
    logic [7:0] th_r, th_nxt;
    logic [7:0] tl_r, tl_nxt;
    logic [17:0] nv_r, nv_nxt;
    logic [15:0] temp_r, temp_nxt;
    logic alarm_r, alarm_nxt;
    logic fault_r, fault_nxt;
    logic [11:0] sense_s1_r, sense_s2_r;
    logic [CNT_W-1:0] conv_len;
    logic [15:0] res_mask;
    logic [15:0] sample;
    logic signed [7:0] cmp_val;

    // the sensor value comes from outside the clock domain
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            sense_s1_r <= 12'h000;
            sense_s2_r <= 12'h000;
        end
        else
        begin
            sense_s1_r <= i_sense_temp;
            sense_s2_r <= sense_s1_r;
        end
    end

    always_comb
    begin
        conv_len = CNT_W'(CONV_CYCLES >> (2'h3 - res_r));
        res_mask = 16'hffff << (2'h3 - res_r);
        sample = {{(15 - SIGN_BIT){sense_s2_r[SIGN_BIT]}}, sense_s2_r}
            & res_mask;
        cmp_val = sample[11:4];
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        grace_nxt = grace_r;
        res_nxt = res_r;
        th_nxt = th_r;
        tl_nxt = tl_r;
        nv_nxt = nv_r;
        temp_nxt = temp_r;
        alarm_nxt = alarm_r;
        fault_nxt = fault_r;
        unique case (state_r)
            DEV_IDLE:
            begin
                grace_nxt = '0;
                if (link.cfg_wr)
                begin
                    res_nxt = link.cfg_res;
                    th_nxt = link.cfg_th;
                    tl_nxt = link.cfg_tl;
                end
                if (link.cmd_valid && link.cmd_code == CMD_CONVERT)
                begin
                    state_nxt = DEV_CONV;
                    cnt_nxt = conv_len - CNT_W'(1);
                    fault_nxt = 1'b0;
                end
                else if (link.cmd_valid && link.cmd_code == CMD_COPY)
                begin
                    state_nxt = DEV_COPY;
                    cnt_nxt = CNT_W'(WR_CYCLES) - CNT_W'(1);
                    fault_nxt = 1'b0;
                end
            end
            DEV_CONV:
            begin
                cnt_nxt = cnt_r - CNT_W'(1);
                if (cnt_r == '0)
                begin
                    state_nxt = DEV_IDLE;
                    temp_nxt = sample;
                    alarm_nxt = (cmp_val >= $signed(th_r))
                        || (cmp_val <= $signed(tl_r));
                end
            end
            DEV_COPY:
            begin
                cnt_nxt = cnt_r - CNT_W'(1);
                if (cnt_r == '0)
                begin
                    state_nxt = DEV_IDLE;
                    nv_nxt = {res_r, th_r, tl_r};
                end
            end
            default:
            begin
                state_nxt = DEV_IDLE;
            end
        endcase
        // supply must be strong after the grace time
        if (state_r != DEV_IDLE)
        begin
            if (grace_r < CNT_W'(SPU_GRACE))
            begin
                grace_nxt = grace_r + CNT_W'(1);
            end
            else if (!link.spu)
            begin
                fault_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r <= DEV_IDLE;
            cnt_r <= '0;
            grace_r <= '0;
            res_r <= RES_RST;
            th_r <= TH_RST;
            tl_r <= TL_RST;
            nv_r <= {RES_RST, TH_RST, TL_RST};
            temp_r <= TEMP_RST;
            alarm_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            grace_r <= grace_nxt;
            res_r <= res_nxt;
            th_r <= th_nxt;
            tl_r <= tl_nxt;
            nv_r <= nv_nxt;
            temp_r <= temp_nxt;
            alarm_r <= alarm_nxt;
            fault_r <= fault_nxt;
        end
    end

    // busy mirrors the state, registered separately for a clean output
    logic busy_r;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            busy_r <= 1'b0;
        end
        else
        begin
            busy_r <= (state_nxt != DEV_IDLE);
        end
    end

    assign o_busy = busy_r;
    assign o_alarm = alarm_r;
    assign link.busy = busy_r;
    assign link.alarm = alarm_r;
    assign link.pwr_fault = fault_r;
    assign link.temp = temp_r;
    assign link.nv_cfg = nv_r;
endmodule

// ==== tcr_bus_master_ctl.sv ====
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module tcr_bus_master_ctl
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    tcr_link_if.mst link
);
    import tcr_pkg::*;

    tcr_mst_state_t state_r, state_nxt;
    logic is_copy_r, is_copy_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [23:0] cfg_r, cfg_nxt;
    logic [IRQ_W-1:0] sts_r, sts_nxt;
    logic [IRQ_W-1:0] msk_r, msk_nxt;
    logic irq_r, irq_nxt;
    logic cmd_v_r, cmd_v_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic cfg_wr_r, cfg_wr_nxt;
    logic spu_r, spu_nxt;
    logic [31:0] wmask;
    logic do_wr;
    logic [IRQ_W-1:0] ev;

    always_comb
    begin
        wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        // transfer completes on the edge where waitrequest is low
        do_wr = i_avs_write && !wait_r;
        wait_nxt = 1'b1;
        if ((i_avs_read || i_avs_write) && wait_r)
        begin
            wait_nxt = 1'b0;
        end
        rdata_nxt = rdata_r;
        if ((i_avs_read) && wait_r)
        begin
            unique case (i_avs_address)
                OFS_CFG: rdata_nxt = {8'h00, cfg_r};
                OFS_STAT: rdata_nxt = {27'h0, link.pwr_fault, link.busy,
                    link.alarm, spu_r, state_r != MST_IDLE};
                OFS_TEMP: rdata_nxt = {16'h0000, link.temp};
                OFS_IRQ_STS: rdata_nxt = {29'h0, sts_r};
                OFS_IRQ_MSK: rdata_nxt = {29'h0, msk_r};
                // same field layout as the config register
                OFS_NVCFG: rdata_nxt = {8'h00, link.nv_cfg[7:0],
                    link.nv_cfg[15:8], 6'h00, link.nv_cfg[17:16]};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        is_copy_nxt = is_copy_r;
        cfg_nxt = cfg_r;
        msk_nxt = msk_r;
        cmd_v_nxt = 1'b0;
        cmd_nxt = cmd_r;
        cfg_wr_nxt = 1'b0;
        spu_nxt = spu_r;
        ev = '0;
        if (do_wr && i_avs_address == OFS_CFG)
        begin
            cfg_nxt = (cfg_r & ~wmask[23:0]) | (i_avs_writedata[23:0]
                & wmask[23:0]);
        end
        if (do_wr && i_avs_address == OFS_IRQ_MSK)
        begin
            msk_nxt = (msk_r & ~wmask[IRQ_W-1:0])
                | (i_avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
        end
        unique case (state_r)
            MST_IDLE:
            begin
                if (do_wr && i_avs_address == OFS_CTRL
                    && i_avs_byteenable[0])
                begin
                    if (i_avs_writedata[CTRL_CONVERT]
                        || i_avs_writedata[CTRL_COPY])
                    begin
                        cmd_v_nxt = 1'b1;
                        is_copy_nxt = !i_avs_writedata[CTRL_CONVERT];
                        cmd_nxt = i_avs_writedata[CTRL_CONVERT]
                            ? CMD_CONVERT : CMD_COPY;
                        // pullup in the command's own cycle
                        spu_nxt = 1'b1;
                        state_nxt = MST_ARM;
                    end
                    else if (i_avs_writedata[CTRL_CFG_PUSH])
                    begin
                        cfg_wr_nxt = 1'b1;
                    end
                end
            end
            MST_ARM:
            begin
                if (do_wr && i_avs_address == OFS_CTRL)
                begin
                    ev[IRQ_REFUSED] = 1'b1;
                end
                if (link.busy)
                begin
                    state_nxt = MST_HOLD;
                end
            end
            MST_HOLD:
            begin
                if (do_wr && i_avs_address == OFS_CTRL)
                begin
                    ev[IRQ_REFUSED] = 1'b1;
                end
                if (!link.busy)
                begin
                    spu_nxt = 1'b0;
                    state_nxt = MST_IDLE;
                    ev[IRQ_CONV_DONE] = !is_copy_r;
                    ev[IRQ_COPY_DONE] = is_copy_r;
                end
            end
            default:
            begin
                state_nxt = MST_IDLE;
            end
        endcase
        // set wins over write-one-to-clear
        sts_nxt = sts_r;
        if (do_wr && i_avs_address == OFS_IRQ_STS)
        begin
            sts_nxt = sts_r & ~(i_avs_writedata[IRQ_W-1:0]
                & wmask[IRQ_W-1:0]);
        end
        sts_nxt = sts_nxt | ev;
        irq_nxt = |(sts_nxt & msk_nxt);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r <= MST_IDLE;
            is_copy_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            cfg_r <= {TL_RST, TH_RST, 6'h00, RES_RST};
            sts_r <= '0;
            msk_r <= '0;
            irq_r <= 1'b0;
            cmd_v_r <= 1'b0;
            cmd_r <= 8'h00;
            cfg_wr_r <= 1'b0;
            spu_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            is_copy_r <= is_copy_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            cfg_r <= cfg_nxt;
            sts_r <= sts_nxt;
            msk_r <= msk_nxt;
            irq_r <= irq_nxt;
            cmd_v_r <= cmd_v_nxt;
            cmd_r <= cmd_nxt;
            cfg_wr_r <= cfg_wr_nxt;
            spu_r <= spu_nxt;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_irq = irq_r;
    assign link.cmd_valid = cmd_v_r;
    assign link.cmd_code = cmd_r;
    assign link.cfg_wr = cfg_wr_r;
    assign link.cfg_res = cfg_r[CFG_RES_LSB +: 2];
    assign link.cfg_th = cfg_r[CFG_TH_LSB +: 8];
    assign link.cfg_tl = cfg_r[CFG_TL_LSB +: 8];
    assign link.spu = spu_r;
endmodule

// ==== tcr_conv_checker.sv ====
`timescale 1ns/10ps
module tcr_conv_checker
import tcr_pkg::*;
#(
    parameter int CONV_MAX = 64
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cfg_wr,
    input wire logic spu,
    input wire logic busy,
    input wire logic pwr_fault,
    input wire logic [15:0] temp
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_cmd_starts_busy: assert property (cmd_valid && cmd_code == CMD_CONVERT
        && !busy |=> busy) else $error("convert command did not start");
    a_spu_with_cmd: assert property (cmd_valid && (cmd_code == CMD_CONVERT
        || cmd_code == CMD_COPY) |-> spu)
        else $error("strong pullup late");
    a_spu_covers_busy: assert property (busy |-> spu)
        else $error("busy without strong pullup");
    a_quiet_under_spu: assert property ($past(spu) && spu |-> !cmd_valid
        && !cfg_wr) else $error("traffic under strong pullup");
    a_busy_needs_cmd: assert property ($rose(busy) |-> $past(cmd_valid))
        else $error("busy rose without a command");
    a_conv_bounded: assert property ($rose(busy) |=> ##[0:CONV_MAX] !busy)
        else $error("operation overran its time");
    a_sign_copies: assert property (temp[15:11] == {5{temp[11]}})
        else $error("result high bits not sign");
    a_result_held: assert property (!$fell(busy) |-> $stable(temp))
        else $error("result changed outside completion");
    a_reset_result: assert property ($fell(i_rst) |-> temp == TEMP_RST)
        else $error("result reset value wrong");
    a_no_fault: assert property (!pwr_fault)
        else $error("device reported power fault");

    c_convert: cover property (cmd_valid && cmd_code == CMD_CONVERT);
    c_copy: cover property (cmd_valid && cmd_code == CMD_COPY);
    c_done: cover property ($fell(busy));
endmodule

// ==== temp_conversion_readout_test.sv ====
`timescale 1ns/10ps
module temp_conversion_readout_test;
    import tcr_pkg::*;
    localparam int CONV_C = 64;
    typedef struct {
        logic [1:0] res;
        logic [7:0] th;
        logic [7:0] tl;
        logic [11:0] s;
        logic [15:0] t;
        logic a;
    } tcr_row_t;
    // inputs, then expected result and alarm
    tcr_row_t rows [7] = '{'{2'h3, 8'h7f, 8'h80, 12'h191, 16'h0191, 1'b0},
        '{2'h2, 8'h7f, 8'h80, 12'hf5e, 16'hff5e, 1'b0},
        '{2'h1, 8'h7f, 8'h80, 12'h0a2, 16'h00a0, 1'b0},
        '{2'h0, 8'h7f, 8'h80, 12'he6f, 16'hfe68, 1'b0},
        '{2'h3, 8'h19, 8'h80, 12'h191, 16'h0191, 1'b1},
        '{2'h3, 8'h7f, 8'hc9, 12'hc90, 16'hfc90, 1'b1},
        '{2'h3, 8'h7f, 8'h80, 12'h550, 16'h0550, 1'b0}};
    logic i_clk_sys, i_rst, rd, wr, wait_r, irq, alarm, dbusy;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] be;
    logic [11:0] sense;
    int mismatches, samples_checked;

    tcr_link_if link();
    tcr_sensor_dev #(.CONV_CYCLES(CONV_C), .WR_CYCLES(16), .SPU_GRACE(4))
    u_tcr_sensor_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_sense_temp(sense), .o_alarm(alarm), .o_busy(dbusy), .link(link));
    tcr_bus_master_ctl u_tcr_bus_master_ctl (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .o_irq(irq),
        .link(link));
    tcr_conv_checker #(.CONV_MAX(CONV_C)) u_tcr_conv_checker (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cfg_wr(link.cfg_wr), .spu(link.spu),
        .busy(link.busy), .pwr_fault(link.pwr_fault), .temp(link.temp));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one avalon transfer, entered just after a rising edge; held until
    // waitrequest is sampled low at a rising edge, data taken there
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (wait_r !== 1'b0 && n < 100);
        if (n >= 100)
            mismatches++;
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // idle edge so the next request is not driven in this step
        @(posedge i_clk_sys);
    endtask

    task wait_for(input int which);
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while ((which == 0 ? irq !== 1'b1 : dbusy !== 1'b0) && n < 300);
        if (n >= 300)
            mismatches++;
        repeat (2) @(posedge i_clk_sys);
    endtask

    initial
    begin
        i_rst = 1'b1;
        {rd, wr, addr, wdata} = '0;
        be = 4'hf;
        sense = 12'h000;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        foreach (rows[i])
        begin
            sense <= rows[i].s;
            bus(1, OFS_CFG, {8'h00, rows[i].tl, rows[i].th, 6'h00,
                rows[i].res});
            bus(1, OFS_CTRL, 32'h4);
            bus(1, OFS_IRQ_MSK, 32'h1);
            bus(1, OFS_CTRL, 32'h1);
            wait_for(0);
            bus(0, OFS_TEMP, 32'h0);
            check(got, {16'h0000, rows[i].t});
            check(alarm, rows[i].a);
            bus(1, OFS_IRQ_STS, 32'h1);
            check(irq, 1'b0);
        end
        // masked interrupt and a refused back-to-back command
        bus(1, OFS_IRQ_MSK, 32'h0);
        bus(1, OFS_CTRL, 32'h1);
        bus(1, OFS_CTRL, 32'h1);
        wait_for(1);
        check(irq, 1'b0);
        bus(0, OFS_IRQ_STS, 32'h0);
        check(got, 32'h5);
        bus(1, OFS_IRQ_MSK, 32'h4);
        check(irq, 1'b1);
        bus(1, OFS_IRQ_STS, 32'h5);
        bus(0, OFS_IRQ_STS, 32'h0);
        check(got, 32'h0);
        // save of configuration to nonvolatile store
        bus(1, OFS_CFG, 32'h00a51001);
        bus(1, OFS_CTRL, 32'h4);
        bus(1, OFS_IRQ_MSK, 32'h2);
        bus(1, OFS_CTRL, 32'h2);
        wait_for(0);
        bus(0, OFS_NVCFG, 32'h0);
        check(got, 32'h00a51001);
        // second reset in mid-run
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        bus(0, OFS_TEMP, 32'h0);
        check(got, 32'h550);
        bus(0, OFS_CFG, 32'h0);
        check(got, 32'h00807f03);
        bus(0, OFS_NVCFG, 32'h0);
        check(got, 32'h00807f03);
        bus(0, OFS_STAT, 32'h0);
        check(got, 32'h0);
        bus(0, 5'h1c, 32'h0);
        check(got, 32'h0);
        // device resolution after reset, with no config push
        sense <= 12'hf5f;
        bus(1, OFS_IRQ_MSK, 32'h1);
        bus(1, OFS_CTRL, 32'h1);
        wait_for(0);
        bus(0, OFS_TEMP, 32'h0);
        check(got, 32'h0000ff5f);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        mismatches++;
        conclude();
    end
endmodule
